// File: core/sdr_status_regs.sv
// Stepper driver configuration and status register bank
module sdr_status_regs (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_spi_clk,
	input wire logic i_spi_di,
	input wire logic i_spi_cs_n,
	output logic o_spi_do,
	output logic o_spi_do_oe,
	input wire logic i_next,
	input wire logic i_dir,
	input wire logic i_thermal_warning,
	input wire logic i_pump_fault,
	input wire logic i_open_coil_x,
	input wire logic i_open_coil_y,
	input wire logic [3:0] i_x_overcurrent,
	input wire logic [3:0] i_y_overcurrent,
	input wire logic i_thermal_shutdown,
	output logic [1:0] o_slope_select,
	output logic [7:0] o_slew_vpus,
	output logic [2:0] o_step_resolution,
	output logic [6:0] o_translator_position
);
	import sdr_pkg::*;

	localparam int SYNC_W = 18;

	// ==========================================================
	// Input synchronisers
	logic [SYNC_W-1:0] sync_in;
	logic [SYNC_W-1:0] sync_out;
	logic sclk_s;
	logic sdi_s;
	logic cs_s;
	logic next_s;
	logic dir_s;
	logic tw_s;
	logic pump_s;
	logic opx_s;
	logic opy_s;
	logic [3:0] oc_x_s;
	logic [3:0] oc_y_s;
	logic tsd_s;

	// Chip select is inverted ahead of the first flop so reset means idle
	assign sync_in = {i_spi_clk, i_spi_di, ~i_spi_cs_n, i_next, i_dir,
		i_thermal_warning, i_pump_fault, i_open_coil_x, i_open_coil_y,
		i_x_overcurrent, i_y_overcurrent, i_thermal_shutdown};
	assign {sclk_s, sdi_s, cs_s, next_s, dir_s, tw_s, pump_s, opx_s, opy_s,
		oc_x_s, oc_y_s, tsd_s} = sync_out;

	sdr_sync_bank #(
		.WIDTH(SYNC_W)
	) u_sync (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_async(sync_in),
		.o_sync(sync_out)
	);

	// ==========================================================
	// Serial link
	sdr_bus_if bus ();

	sdr_spi_link u_link (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_sclk(sclk_s),
		.i_sdi(sdi_s),
		.i_cs(cs_s),
		.o_sdo_oe(o_spi_do_oe),
		.bus(bus)
	);

	// Open-drain data only ever pulls low
	always_ff @(posedge i_clk) begin
		o_spi_do <= 1'b0;
	end

	// ==========================================================
	// Configuration fields
	logic [1:0] slope_r;
	logic [2:0] step_r;

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			slope_r <= SLOPE_RST;
			step_r <= STEP_RST;
		end else if (bus.wr_valid) begin
			if (bus.addr == REG_SLOPE) begin
				slope_r <= bus.wr_data[1:0];
			end
			if (bus.addr == REG_STEP) begin
				step_r <= bus.wr_data[2:0];
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			o_slew_vpus <= SLEW_150;
		end else begin
			unique case (slope_r)
				2'h0: o_slew_vpus <= SLEW_150;
				2'h1: o_slew_vpus <= SLEW_100;
				2'h2: o_slew_vpus <= SLEW_50;
				2'h3: o_slew_vpus <= SLEW_25;
			endcase
		end
	end

	assign o_slope_select = slope_r;
	assign o_step_resolution = step_r;

	// ==========================================================
	// Translator position, advanced on each rising step input
	logic next_prev_r;
	logic next_pulse;
	logic [6:0] pos_r;

	assign next_pulse = next_s & ~next_prev_r;

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			next_prev_r <= 1'b0;
			pos_r <= POS_RST;
		end else begin
			next_prev_r <= next_s;
			// Reserved resolution yields zero advance: the motor holds
			if (next_pulse) begin
				if (dir_s) begin
					pos_r <= pos_r - step_incr(step_r);
				end else begin
					pos_r <= pos_r + step_incr(step_r);
				end
			end
		end
	end

	assign o_translator_position = pos_r;

	// ==========================================================
	// Status flags
	logic [6:0] live_r;
	logic [3:0] xoc_r;
	logic [3:0] yoc_r;
	logic tsd_r;
	logic [6:0] rd_addr_r;
	logic rd_pending_r;
	logic clr_x;
	logic clr_y;

	assign clr_x = bus.frame_done && rd_pending_r && rd_addr_r == REG_XOC;
	assign clr_y = bus.frame_done && rd_pending_r && rd_addr_r == REG_YOC;

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			live_r <= STATUS_RST[6:0];
		end else begin
			live_r <= 7'h00;
			live_r[BIT_TW] <= tw_s;
			live_r[BIT_PUMP] <= pump_s;
			live_r[BIT_OPX] <= opx_s;
			live_r[BIT_OPY] <= opy_s;
		end
	end

	// A new fault in the clearing cycle survives the clear
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			xoc_r <= STATUS_RST[3:0];
			yoc_r <= STATUS_RST[3:0];
			tsd_r <= 1'b0;
		end else begin
			xoc_r <= (xoc_r & {4{~clr_x}}) | oc_x_s;
			yoc_r <= (yoc_r & {4{~clr_y}}) | oc_y_s;
			tsd_r <= (tsd_r & ~clr_y) | tsd_s;
		end
	end

	// ==========================================================
	// Read snapshot, taken once the command byte is in
	logic [6:0] sr_x;
	logic [6:0] sr_y;

	always_comb begin
		sr_x = 7'h00;
		sr_y = 7'h00;
		sr_x[OC_MSB:OC_LSB] = xoc_r;
		sr_y[OC_MSB:OC_LSB] = yoc_r;
		sr_y[BIT_TSD] = tsd_r;
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			bus.rd_data <= STATUS_RST;
			rd_addr_r <= 7'h00;
			rd_pending_r <= 1'b0;
		end else if (bus.addr_valid) begin
			rd_addr_r <= bus.addr;
			rd_pending_r <= ~bus.cmd_write;
			unique case (bus.addr)
				REG_STEP: bus.rd_data <= {5'h00, step_r};
				REG_SLOPE: bus.rd_data <= {6'h00, slope_r};
				REG_LIVE: bus.rd_data <= with_parity(live_r);
				REG_XOC: bus.rd_data <= with_parity(sr_x);
				REG_YOC: bus.rd_data <= with_parity(sr_y);
				REG_POS: bus.rd_data <= with_parity(pos_r);
				default: bus.rd_data <= 8'h00;
			endcase
		end else if (bus.frame_done) begin
			rd_pending_r <= 1'b0;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	sequence s_slope_25;
		slope_r == 2'h3 ##1 slope_r == 2'h3;
	endsequence

	sequence s_pos_read;
		bus.addr_valid && !bus.cmd_write && bus.addr == REG_POS;
	endsequence

	sequence s_live_read;
		bus.addr_valid && !bus.cmd_write && bus.addr == REG_LIVE;
	endsequence

	a_slew_code: assert property (s_slope_25 |-> o_slew_vpus == SLEW_25)
		else $error("slew rate does not match slope code 11");

	a_slope_write: assert property (bus.wr_valid
		&& bus.addr == REG_SLOPE |=> slope_r == $past(bus.wr_data[1:0]))
		else $error("slope field did not take the written code");

	a_step_fine: assert property (next_pulse && !dir_s
		&& step_r == STEP_32 |=> pos_r == $past(pos_r) + 7'h01)
		else $error("fine step did not advance position by one");

	a_step_full: assert property (next_pulse && dir_s
		&& step_r == STEP_FULL |=> pos_r == $past(pos_r) - 7'h20)
		else $error("full step did not move position back by 32");

	// The reserved code must hold the motor rather than move it
	a_step_hold: assert property (next_pulse && step_r == 3'h7
		|=> pos_r == $past(pos_r))
		else $error("reserved step mode moved the position");

	a_status_reset: assert property (disable iff (1'b0) !i_resetn
		|=> live_r == 7'h00 && xoc_r == 4'h0 && yoc_r == 4'h0 && !tsd_r)
		else $error("status not zero after reset");

	a_live_follow: assert property (!tw_s && !opx_s ##1 1'b1
		|-> !live_r[BIT_TW] && !live_r[BIT_OPX])
		else $error("live flag did not follow its condition");

	a_live_rise: assert property (tw_s && opy_s
		|=> live_r[BIT_TW] && live_r[BIT_OPY])
		else $error("live flag did not report its condition");

	a_live_read: assert property (s_live_read
		|=> bus.rd_data == {^$past(live_r), $past(live_r)})
		else $error("live flag readback wrong");

	a_x_latch: assert property (oc_x_s != 4'h0
		|=> (xoc_r & $past(oc_x_s)) == $past(oc_x_s))
		else $error("X over-current not latched");

	a_y_latch: assert property (oc_y_s[3] || tsd_s
		|=> (yoc_r[3] || !$past(oc_y_s[3])) && (tsd_r || !$past(tsd_s)))
		else $error("Y over-current or shutdown not latched");

	a_tsd_hold: assert property (tsd_r && !clr_y |=> tsd_r)
		else $error("thermal shutdown flag lost without a read");

	a_pos_field: assert property (s_pos_read
		|=> bus.rd_data == {^$past(pos_r), $past(pos_r)})
		else $error("position readback wrong");

	a_pump_bit: assert property (pump_s |=> live_r[BIT_PUMP])
		else $error("pump fault not reported");

	a_oc_hold: assert property (xoc_r[0] && !clr_x |=> xoc_r[0])
		else $error("over-current flag lost without a read");

	a_latch_clear: assert property (clr_y && !oc_y_s[2] && !tsd_s
		|=> !yoc_r[2] && !tsd_r)
		else $error("latched flag not cleared by read");

	a_x_clear: assert property (clr_x && oc_x_s == 4'h0
		|=> xoc_r == 4'h0)
		else $error("X over-current flags not cleared by read");

endmodule : sdr_status_regs

// File: core/sdr_pkg.sv
// Shared constants for the stepper driver status register bank
package sdr_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [6:0] REG_STEP = 7'h01;
	localparam logic [6:0] REG_SLOPE = 7'h02;
	localparam logic [6:0] REG_LIVE = 7'h04;
	localparam logic [6:0] REG_XOC = 7'h05;
	localparam logic [6:0] REG_YOC = 7'h06;
	localparam logic [6:0] REG_POS = 7'h07;

	// ==========================================================
	// Field positions
	localparam int BIT_PAR = 7;
	localparam int BIT_TW = 6;
	localparam int BIT_PUMP = 5;
	localparam int BIT_OPX = 3;
	localparam int BIT_OPY = 2;
	localparam int OC_MSB = 6;
	localparam int OC_LSB = 3;
	localparam int BIT_TSD = 2;

	// ==========================================================
	// Reset values
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [1:0] SLOPE_RST = 2'h0;
	localparam logic [2:0] STEP_RST = 3'h0;
	localparam logic [6:0] POS_RST = 7'h00;

	// ==========================================================
	// Slope codes and their slew rates in V/us
	localparam logic [7:0] SLEW_150 = 8'h96;
	localparam logic [7:0] SLEW_100 = 8'h64;
	localparam logic [7:0] SLEW_50 = 8'h32;
	localparam logic [7:0] SLEW_25 = 8'h19;

	// ==========================================================
	// Step resolution codes
	localparam logic [2:0] STEP_32 = 3'h0;
	localparam logic [2:0] STEP_16 = 3'h1;
	localparam logic [2:0] STEP_8 = 3'h2;
	localparam logic [2:0] STEP_4 = 3'h3;
	localparam logic [2:0] STEP_HALF_UNC = 3'h4;
	localparam logic [2:0] STEP_HALF_CMP = 3'h5;
	localparam logic [2:0] STEP_FULL = 3'h6;

	// ==========================================================
	// Serial frame: command byte then data byte
	localparam logic [4:0] CMD_LAST_BIT = 5'h07;
	localparam logic [4:0] DATA_FIRST_BIT = 5'h08;
	localparam logic [4:0] FRAME_LAST_BIT = 5'h0F;
	localparam logic [4:0] FRAME_BITS = 5'h10;

	// Even parity over the seven payload bits
	function automatic logic [7:0] with_parity(input logic [6:0] payload);
		with_parity = {^payload, payload};
	endfunction : with_parity

	// Translator advance per input pulse, in 1/32 micro-steps
	function automatic logic [6:0] step_incr(input logic [2:0] res);
		unique case (res)
			STEP_32: step_incr = 7'h01;
			STEP_16: step_incr = 7'h02;
			STEP_8: step_incr = 7'h04;
			STEP_4: step_incr = 7'h08;
			STEP_HALF_UNC, STEP_HALF_CMP: step_incr = 7'h10;
			STEP_FULL: step_incr = 7'h20;
			default: step_incr = 7'h00;
		endcase
	endfunction : step_incr

endpackage : sdr_pkg

// File: core/sdr_bus_if.sv
// Carrier between the serial link and the register core
interface sdr_bus_if;
	logic addr_valid;
	logic cmd_write;
	logic [6:0] addr;
	logic wr_valid;
	logic [7:0] wr_data;
	logic frame_done;
	logic [7:0] rd_data;

	modport link (
		output addr_valid,
		output cmd_write,
		output addr,
		output wr_valid,
		output wr_data,
		output frame_done,
		input rd_data
	);

	modport core (
		input addr_valid,
		input cmd_write,
		input addr,
		input wr_valid,
		input wr_data,
		input frame_done,
		output rd_data
	);
endinterface : sdr_bus_if

// File: core/sdr_sync_bank.sv
// Two-flop synchronisers for asynchronous inputs
module sdr_sync_bank #(
	parameter int WIDTH = 1
) (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	import sdr_pkg::*;

	if (WIDTH < 1) begin : g_bad_width
		$error("sdr_sync_bank: WIDTH must be at least 1");
	end

	for (genvar b = 0; b < WIDTH; b++) begin : g_bit
		logic meta_r;
		logic hold_r;
		always_ff @(posedge i_clk) begin
			if (!i_resetn) begin
				meta_r <= 1'b0;
				hold_r <= 1'b0;
			end else begin
				meta_r <= i_async[b];
				hold_r <= meta_r;
			end
		end
		assign o_sync[b] = hold_r;
	end

endmodule : sdr_sync_bank

// File: core/sdr_spi_link.sv
// Serial slave: oversampled link clock, command and data byte framing
module sdr_spi_link (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_sclk,
	input wire logic i_sdi,
	input wire logic i_cs,
	output logic o_sdo_oe,
	sdr_bus_if.link bus
);
	import sdr_pkg::*;

	typedef enum logic [1:0] {SP_IDLE, SP_CMD, SP_DATA} sdr_spi_st_t;

	sdr_spi_st_t state_r;
	logic sclk_prev_r;
	logic [4:0] bit_cnt_r;
	logic [7:0] rx_r;
	logic [7:0] tx_r;
	logic rise;
	logic fall;
	logic [7:0] rx_nxt;

	assign rise = i_sclk & ~sclk_prev_r;
	assign fall = ~i_sclk & sclk_prev_r;
	assign rx_nxt = {rx_r[6:0], i_sdi};

	// ==========================================================
	// Frame sequencing
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			state_r <= SP_IDLE;
			bit_cnt_r <= 5'h00;
			sclk_prev_r <= 1'b0;
			rx_r <= 8'h00;
		end else begin
			sclk_prev_r <= i_sclk;
			if (rise) begin
				rx_r <= rx_nxt;
			end
			unique case (state_r)
				SP_IDLE: begin
					bit_cnt_r <= 5'h00;
					if (i_cs) begin
						state_r <= SP_CMD;
					end
				end
				SP_CMD: begin
					if (!i_cs) begin
						state_r <= SP_IDLE;
					end else if (rise) begin
						bit_cnt_r <= bit_cnt_r + 5'h01;
						if (bit_cnt_r == CMD_LAST_BIT) begin
							state_r <= SP_DATA;
						end
					end
				end
				SP_DATA: begin
					if (!i_cs) begin
						state_r <= SP_IDLE;
					end else if (rise && bit_cnt_r != FRAME_BITS) begin
						bit_cnt_r <= bit_cnt_r + 5'h01;
					end
				end
			endcase
		end
	end

	// ==========================================================
	// Pulses toward the register core
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			bus.addr_valid <= 1'b0;
			bus.cmd_write <= 1'b0;
			bus.addr <= 7'h00;
			bus.wr_valid <= 1'b0;
			bus.wr_data <= 8'h00;
			bus.frame_done <= 1'b0;
		end else begin
			bus.addr_valid <= 1'b0;
			bus.wr_valid <= 1'b0;
			bus.frame_done <= 1'b0;
			if (state_r == SP_CMD && i_cs && rise &&
				bit_cnt_r == CMD_LAST_BIT) begin
				bus.addr_valid <= 1'b1;
				bus.cmd_write <= rx_nxt[7];
				bus.addr <= rx_nxt[6:0];
			end
			if (state_r == SP_DATA && i_cs && rise &&
				bit_cnt_r == FRAME_LAST_BIT && bus.cmd_write) begin
				bus.wr_valid <= 1'b1;
				bus.wr_data <= rx_nxt;
			end
			// Only a complete frame counts; a cut-short read clears nothing
			if (state_r == SP_DATA && !i_cs && bit_cnt_r == FRAME_BITS) begin
				bus.frame_done <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Open-drain output: drive only to pull low
	always_ff @(posedge i_clk) begin
		if (!i_resetn || !i_cs) begin
			o_sdo_oe <= 1'b0;
			tx_r <= 8'h00;
		end else if (fall && state_r == SP_DATA && !bus.cmd_write) begin
			if (bit_cnt_r == DATA_FIRST_BIT) begin
				o_sdo_oe <= ~bus.rd_data[7];
				tx_r <= {bus.rd_data[6:0], 1'b0};
			end else if (bit_cnt_r < FRAME_BITS) begin
				o_sdo_oe <= ~tx_r[7];
				tx_r <= {tx_r[6:0], 1'b0};
			end else begin
				o_sdo_oe <= 1'b0;
			end
		end
	end

endmodule : sdr_spi_link

// File: tb/sdr_host_model.sv
// Serial host model that frames commands to the status register bank
module sdr_host_model (
	output logic o_sclk,
	output logic o_sdi,
	output logic o_cs_n,
	input wire logic i_sdo_line
);
	timeunit 1ns;
	timeprecision 100ps;

	localparam int HALF_NS = 16;

	initial begin
		o_sclk = 1'b0;
		o_sdi = 1'b0;
		o_cs_n = 1'b1;
	end

	// ==========================================================
	// Frame: sends bits 15 down to 16-nbits, so a short frame drops the tail
	task automatic frame(input logic [7:0] cmd, input logic [7:0] wdat,
		input int nbits, output logic [7:0] rdat);
		logic [15:0] word;
		word = {cmd, wdat};
		rdat = 8'h00;
		o_cs_n = 1'b0;
		#(HALF_NS);
		for (int i = 15; i >= 16 - nbits; i--) begin
			o_sdi = word[i];
			#(HALF_NS);
			o_sclk = 1'b1;
			if (i < 8) begin
				rdat[i] = i_sdo_line;
			end
			#(HALF_NS);
			o_sclk = 1'b0;
		end
		// Inverted so that a stale data bit is never read as a valid one
		o_sdi = ~o_sdi;
		o_cs_n = 1'b1;
		#(2 * HALF_NS);
	endtask : frame
endmodule : sdr_host_model

// File: tb/tb_stepper_driver_status_regs.sv
// Self-checking testbench for the stepper driver status register bank
module tb_stepper_driver_status_regs;
	timeunit 1ns;
	timeprecision 100ps;
	import sdr_pkg::*;

	logic i_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic spi_clk, spi_di, spi_cs_n, sdo_line, o_spi_do, o_spi_do_oe;
	logic i_next = 1'b0;
	logic i_dir = 1'b0;
	logic tw = 1'b0;
	logic pump = 1'b0;
	logic open_x = 1'b0;
	logic open_y = 1'b0;
	logic [3:0] x_oc = 4'h0;
	logic [3:0] y_oc = 4'h0;
	logic thermal_shutdown = 1'b0;
	logic [1:0] o_slope_select;
	logic [7:0] o_slew_vpus;
	logic [2:0] o_step_resolution;
	logic [6:0] o_translator_position;
	int failures = 0;
	int tests_run = 0;
	int cycles = 0;

	// Open-drain data line with its pull-up
	assign sdo_line = o_spi_do_oe ? o_spi_do : 1'b1;

	sdr_status_regs u_sdr_status_regs (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_spi_clk(spi_clk),
		.i_spi_di(spi_di),
		.i_spi_cs_n(spi_cs_n),
		.o_spi_do(o_spi_do),
		.o_spi_do_oe(o_spi_do_oe),
		.i_next(i_next),
		.i_dir(i_dir),
		.i_thermal_warning(tw),
		.i_pump_fault(pump),
		.i_open_coil_x(open_x),
		.i_open_coil_y(open_y),
		.i_x_overcurrent(x_oc),
		.i_y_overcurrent(y_oc),
		.i_thermal_shutdown(thermal_shutdown),
		.o_slope_select(o_slope_select),
		.o_slew_vpus(o_slew_vpus),
		.o_step_resolution(o_step_resolution),
		.o_translator_position(o_translator_position)
	);

	sdr_host_model u_sdr_host_model (
		.o_sclk(spi_clk),
		.o_sdi(spi_di),
		.o_cs_n(spi_cs_n),
		.i_sdo_line(sdo_line)
	);

	initial begin
		forever #2 i_clk = ~i_clk;
	end

	// ==========================================================
	// Expectations
	function automatic logic [7:0] par8(input logic [6:0] p);
		return {^p, p};
	endfunction : par8

	function automatic logic [7:0] slew_of(input logic [1:0] c);
		case (c)
			2'h0: return 8'h96;
			2'h1: return 8'h64;
			2'h2: return 8'h32;
			default: return 8'h19;
		endcase
	endfunction : slew_of

	function automatic logic [6:0] incr_of(input logic [2:0] r);
		if (r == 3'h7) return 7'h00;
		if (r == 3'h6) return 7'h20;
		if (r >= 3'h4) return 7'h10;
		return 7'h01 << r;
	endfunction : incr_of

	// ==========================================================
	// Checks and bus cycles
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic test_done();
		$display("checks %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : test_done

	// Data line must stay released during a write frame
	task automatic wr(input logic [6:0] a, input logic [7:0] v);
		logic [7:0] d;
		u_sdr_host_model.frame({1'b1, a}, v, 16, d);
		chk(d, 8'hFF);
		repeat (6) @(negedge i_clk);
	endtask : wr

	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		u_sdr_host_model.frame({1'b0, a}, 8'h00, 16, d);
		repeat (6) @(negedge i_clk);
	endtask : rd

	task automatic step_pulse();
		repeat (3) @(negedge i_clk);
		i_next = 1'b1;
		repeat (4) @(negedge i_clk);
		i_next = 1'b0;
		repeat (4) @(negedge i_clk);
	endtask : step_pulse

	always @(posedge i_clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			failures = failures + 1;
			test_done();
		end
	end

	// ==========================================================
	// Main sequence
	initial begin
		logic [7:0] d;
		logic [6:0] pos;
		logic [3:0] lv, xv, yv;
		logic t;
		void'($urandom(44210));
		repeat (6) @(negedge i_clk);
		i_resetn = 1'b1;
		repeat (5) @(negedge i_clk);
		chk(o_slew_vpus, 8'h96);
		chk({1'b0, o_translator_position}, 8'h00);
		for (int a = 4; a < 8; a++) begin
			rd(7'(a), d);
			chk(d, 8'h00);
		end
		for (int c = 3; c >= 0; c--) begin
			wr(REG_SLOPE, 8'(c));
			chk({6'h00, o_slope_select}, 8'(c));
			chk(o_slew_vpus, slew_of(2'(c)));
			rd(REG_SLOPE, d);
			chk(d, 8'(c));
		end
		wr(REG_POS, 8'h55);
		rd(REG_POS, d);
		chk(d, 8'h00);
		rd(7'h10, d);
		chk(d, 8'h00);
		pos = 7'h00;
		for (int r = 0; r < 8; r++) begin
			wr(REG_STEP, 8'(r));
			chk({5'h00, o_step_resolution}, 8'(r));
			rd(REG_STEP, d);
			chk(d, 8'(r));
			repeat (1 + $urandom % 4) begin
				i_dir = 1'($urandom);
				step_pulse();
				pos = i_dir ? pos - incr_of(3'(r)) : pos + incr_of(3'(r));
			end
			chk({1'b0, o_translator_position}, {1'b0, pos});
			rd(REG_POS, d);
			chk(d, par8(pos));
		end
		for (int k = 0; k < 6; k++) begin
			lv = (k == 0) ? 4'hF : (k == 1) ? 4'h0 : 4'($urandom);
			{tw, pump, open_x, open_y} = lv;
			repeat (4) @(negedge i_clk);
			rd(REG_LIVE, d);
			chk(d, par8({lv[3:2], 1'b0, lv[1:0], 2'b00}));
		end
		for (int k = 0; k < 6; k++) begin
			xv = (k == 0) ? 4'hF : 4'($urandom);
			yv = (k == 0) ? 4'h0 : 4'($urandom);
			t = (k == 0) ? 1'b1 : 1'($urandom);
			x_oc = xv;
			y_oc = yv;
			thermal_shutdown = t;
			repeat (4) @(negedge i_clk);
			x_oc = 4'h0;
			y_oc = 4'h0;
			thermal_shutdown = 1'b0;
			repeat (4) @(negedge i_clk);
			// Aborted read after the command byte must leave the flags set
			u_sdr_host_model.frame({1'b0, REG_XOC}, 8'h00, 8, d);
			repeat (6) @(negedge i_clk);
			rd(REG_XOC, d);
			chk(d, par8({xv, 3'b000}));
			rd(REG_YOC, d);
			chk(d, par8({yv, t, 2'b00}));
			rd(REG_XOC, d);
			chk(d, 8'h00);
			rd(REG_YOC, d);
			chk(d, 8'h00);
		end
		// Non-default fields so the mid-run reset has something to clear
		wr(REG_SLOPE, 8'h03);
		x_oc = 4'h2;
		repeat (4) @(negedge i_clk);
		x_oc = 4'h0;
		i_resetn = 1'b0;
		repeat (6) @(negedge i_clk);
		i_resetn = 1'b1;
		repeat (5) @(negedge i_clk);
		chk({1'b0, o_translator_position}, 8'h00);
		chk(o_slew_vpus, 8'h96);
		chk({6'h00, o_slope_select}, 8'h00);
		chk({5'h00, o_step_resolution}, 8'h00);
		rd(REG_XOC, d);
		chk(d, 8'h00);
		test_done();
	end
endmodule : tb_stepper_driver_status_regs
